// ### verilog/aal_pkg.sv
// Purpose: Constants for the accumulator ALU, carry, shift and skip datapath
// Assumes: Instruction bits numbered 0 (MSB) to 15 (LSB), held as word[15:0]
// Notes:   Instruction bit k sits at word index 15-k
package aal_pkg;

    // ==================================================
    // Function codes
    typedef enum logic [2:0]
    {
        AAL_INVERT_OP    = 3'h0,
        AAL_SIGN_FLIP_OP = 3'h1,
        AAL_COPY_OP      = 3'h2,
        AAL_INC_OP       = 3'h3,
        AAL_ADD_COMP_OP  = 3'h4,
        AAL_SUB_OP       = 3'h5,
        AAL_ADD_OP       = 3'h6,
        AAL_AND_OP       = 3'h7
    } aal_func_t;

    // ==================================================
    // Instruction field positions (word index)
    localparam int AAL_ALU_BIT      = 15;
    localparam int AAL_SRC_HI       = 14;
    localparam int AAL_SRC_LO       = 13;
    localparam int AAL_DST_HI       = 12;
    localparam int AAL_DST_LO       = 11;
    localparam int AAL_FUNC_HI      = 10;
    localparam int AAL_FUNC_LO      = 8;
    localparam int AAL_SHIFT_HI     = 7;
    localparam int AAL_SHIFT_LO     = 6;
    localparam int AAL_CARRY_HI     = 5;
    localparam int AAL_CARRY_LO     = 4;
    localparam int AAL_NOLOAD_BIT   = 3;
    localparam int AAL_SKIP_HI      = 2;
    localparam int AAL_SKIP_LO      = 0;

    // ==================================================
    // Carry base, shift and skip codes
    localparam logic [1:0] AAL_BASE_CARRY  = 2'h0;
    localparam logic [1:0] AAL_BASE_ZERO   = 2'h1;
    localparam logic [1:0] AAL_BASE_ONE    = 2'h2;
    localparam logic [1:0] AAL_BASE_NCARRY = 2'h3;
    localparam logic [1:0] AAL_ROT_NONE    = 2'h0;
    localparam logic [1:0] AAL_ROT_LEFT    = 2'h1;
    localparam logic [1:0] AAL_ROT_RIGHT   = 2'h2;
    localparam logic [1:0] AAL_ROT_SWAP    = 2'h3;
    localparam logic [2:0] AAL_SKIP_NEVER  = 3'h0;
    localparam logic [2:0] AAL_SKIP_ALWAYS = 3'h1;

    // ==================================================
    // Register map (byte addresses) and reset values
    localparam logic [7:0]  AAL_REG_INSTR  = 8'h00;
    localparam logic [7:0]  AAL_REG_STATUS = 8'h04;
    localparam logic [7:0]  AAL_REG_CARRY  = 8'h08;
    localparam logic [7:0]  AAL_REG_ACC0   = 8'h10;
    localparam logic [7:0]  AAL_REG_ACC3   = 8'h1C;
    localparam logic [15:0] AAL_ACC_RESET  = 16'h0000;
    localparam logic [1:0]  AAL_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  AAL_RESP_SLVERR = 2'h2;

endpackage

// ### verilog/aal_fn_unit.sv
// Purpose: Function generator: eight operations and the carry bit
// Assumes: Combinational, same clock as the caller
// Notes:   Arithmetic carry out taken from a 17-bit sum
`timescale 1ns/10ps
module aal_fn_unit
(
    // Operands
    input  wire logic [2:0]  i_func,
    input  wire logic [15:0] i_src,
    input  wire logic [15:0] i_dst,
    input  wire logic        i_base,
    // Result
    output logic [15:0]      o_res,
    output logic             o_carry
);
    import aal_pkg::*;

    logic [16:0] sum;
    logic        logical;

    always_comb
    begin
        sum     = 17'h00000;
        logical = 1'b0;
        unique case (aal_func_t'(i_func))
            AAL_INVERT_OP:
            begin
                sum     = {1'b0, ~i_src};
                logical = 1'b1;
            end
            AAL_SIGN_FLIP_OP: sum = {1'b0, ~i_src} + 17'h00001;
            AAL_COPY_OP:
            begin
                sum     = {1'b0, i_src};
                logical = 1'b1;
            end
            AAL_INC_OP:       sum = {1'b0, i_src} + 17'h00001;
            AAL_ADD_COMP_OP:  sum = {1'b0, i_dst} + {1'b0, ~i_src};
            AAL_SUB_OP:
                sum = {1'b0, i_dst} + {1'b0, ~i_src} + 17'h00001;
            AAL_ADD_OP:       sum = {1'b0, i_dst} + {1'b0, i_src};
            AAL_AND_OP:
            begin
                sum     = {1'b0, i_src & i_dst};
                logical = 1'b1;
            end
        endcase
        o_res   = sum[15:0];
        // Logical ops leave bit 16 clear, so base passes through
        o_carry = logical ? i_base : (i_base ^ sum[16]);
    end

endmodule // aal_fn_unit

// ### verilog/aal_core.sv
// Purpose: Accumulator ALU with carry, shifter, skip and AXI4-Lite access
// Assumes: Instruction from the sequencer on the same clock; 100 MHz
// Notes:   One instruction per cycle; results land at the next edge
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module aal_core
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    // Sequencer
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_instr,
    output logic             o_done,
    output logic             o_skip,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);
    import aal_pkg::*;

    // ==================================================
    // Reset synchroniser
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ==================================================
    // Architectural state
    logic [15:0] acc [4];
    logic        carry;
    logic [15:0] last_instr;

    // ==================================================
    // AXI write channel capture
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    logic        wr_hit;
    logic        sw_issue;

    assign wr_go  = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit = (aw_addr == AAL_REG_INSTR) || (aw_addr == AAL_REG_STATUS)
                 || (aw_addr == AAL_REG_CARRY)
                 || ((aw_addr >= AAL_REG_ACC0) && (aw_addr <= AAL_REG_ACC3)
                     && (aw_addr[1:0] == 2'h0));
    // Software issue needs both low bytes; the sequencer port wins a clash
    assign sw_issue = wr_go && (aw_addr == AAL_REG_INSTR) && (&w_strb[1:0]);

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= AAL_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready  <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? AAL_RESP_OKAY : AAL_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==================================================
    // Instruction decode
    logic        exec;
    logic [15:0] instr;
    logic [1:0]  src_sel;
    logic [1:0]  dst_sel;
    logic [2:0]  func;
    logic [1:0]  rot_sel;
    logic [1:0]  base_sel;
    logic        no_load;
    logic [2:0]  skip_code;
    logic        base;

    assign instr     = i_instr_valid ? i_instr : w_data[15:0];
    // Only words with the operate bit set run here
    assign exec      = (i_instr_valid || sw_issue) && instr[AAL_ALU_BIT];
    assign src_sel   = instr[AAL_SRC_HI:AAL_SRC_LO];
    assign dst_sel   = instr[AAL_DST_HI:AAL_DST_LO];
    assign func      = instr[AAL_FUNC_HI:AAL_FUNC_LO];
    assign rot_sel   = instr[AAL_SHIFT_HI:AAL_SHIFT_LO];
    assign base_sel  = instr[AAL_CARRY_HI:AAL_CARRY_LO];
    assign no_load   = instr[AAL_NOLOAD_BIT];
    assign skip_code = instr[AAL_SKIP_HI:AAL_SKIP_LO];

    always_comb
    begin
        unique case (base_sel)
            AAL_BASE_CARRY:  base = carry;
            AAL_BASE_ZERO:   base = 1'b0;
            AAL_BASE_ONE:    base = 1'b1;
            AAL_BASE_NCARRY: base = ~carry;
        endcase
    end

    // ==================================================
    // Function generator
    logic [15:0] fn_res;
    logic        fn_carry;

    aal_fn_unit u_fn
    (
        .i_func  (func),
        .i_src   (acc[src_sel]),
        .i_dst   (acc[dst_sel]),
        .i_base  (base),
        .o_res   (fn_res),
        .o_carry (fn_carry)
    );

    // ==================================================
    // Shifter: word is {carry, result}, result[15] is bit 0
    logic [16:0] sh_word;
    logic        res_zero;
    logic        skip_cond;

    always_comb
    begin
        unique case (rot_sel)
            AAL_ROT_NONE:  sh_word = {fn_carry, fn_res};
            AAL_ROT_LEFT:  sh_word = {fn_res[15], fn_res[14:0], fn_carry};
            AAL_ROT_RIGHT: sh_word = {fn_res[0], fn_carry, fn_res[15:1]};
            AAL_ROT_SWAP:  sh_word = {fn_carry, fn_res[7:0], fn_res[15:8]};
        endcase
    end

    // Tested on the shifter output whether or not it is loaded
    assign res_zero = (sh_word[15:0] == 16'h0000);

    always_comb
    begin
        unique case (skip_code)
            3'h0: skip_cond = 1'b0;
            3'h1: skip_cond = 1'b1;
            3'h2: skip_cond = !sh_word[16];
            3'h3: skip_cond = sh_word[16];
            3'h4: skip_cond = res_zero;
            3'h5: skip_cond = !res_zero;
            3'h6: skip_cond = !sh_word[16] || res_zero;
            3'h7: skip_cond = sh_word[16] && !res_zero;
        endcase
    end

    // ==================================================
    // Sequencer answer
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_done     <= 1'b0;
            o_skip     <= 1'b0;
            last_instr <= 16'h0000;
        end
        else
        begin
            o_done <= exec;
            o_skip <= exec && skip_cond;
            if (exec)
            begin
                last_instr <= instr;
            end
        end
    end

    // ==================================================
    // Accumulators and carry; execution beats software writes
    logic [1:0] wr_idx;

    assign wr_idx = aw_addr[3:2];

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
            begin
                acc[i] <= AAL_ACC_RESET;
            end
            carry <= 1'b0;
        end
        else if (exec && !no_load)
        begin
            acc[dst_sel] <= sh_word[15:0];
            carry        <= sh_word[16];
        end
        else if (wr_go && !exec)
        begin
            if ((aw_addr == AAL_REG_CARRY) && w_strb[0])
            begin
                carry <= w_data[0];
            end
            if ((aw_addr >= AAL_REG_ACC0) && (aw_addr <= AAL_REG_ACC3)
                && (aw_addr[1:0] == 2'h0))
            begin
                if (w_strb[0])
                begin
                    acc[wr_idx][7:0] <= w_data[7:0];
                end
                if (w_strb[1])
                begin
                    acc[wr_idx][15:8] <= w_data[15:8];
                end
            end
        end
    end

    // ==================================================
    // AXI read channel
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= AAL_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= AAL_RESP_OKAY;
                if (s_axi_araddr == AAL_REG_INSTR)
                begin
                    s_axi_rdata <= {16'h0000, last_instr};
                end
                else if (s_axi_araddr == AAL_REG_STATUS)
                begin
                    s_axi_rdata <= {30'h00000000, o_skip, carry};
                end
                else if (s_axi_araddr == AAL_REG_CARRY)
                begin
                    s_axi_rdata <= {31'h00000000, carry};
                end
                else if ((s_axi_araddr >= AAL_REG_ACC0) && (s_axi_araddr <= AAL_REG_ACC3)
                         && (s_axi_araddr[1:0] == 2'h0))
                begin
                    s_axi_rdata <= {16'h0000, acc[s_axi_araddr[3:2]]};
                end
                else
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= AAL_RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==================================================
    // Assertions
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_exec_noload;
        exec && no_load;
    endsequence

    sequence s_exec_load;
        exec && !no_load;
    endsequence

    noload_hold_a: assert property (s_exec_noload |=> (acc[$past(dst_sel)] == $past(acc[dst_sel])) && (carry == $past(carry))) else $error("No-load instruction changed state");
    load_dest_a: assert property (s_exec_load |=> (acc[$past(dst_sel)] == $past(sh_word[15:0])) && (carry == $past(sh_word[16]))) else $error("Destination not loaded from shifter");
    base_zero_a: assert property (exec && (base_sel == AAL_BASE_ZERO) && (func == AAL_COPY_OP) && (rot_sel == AAL_ROT_NONE) |-> !sh_word[16]) else $error("Zero base not applied");
    logic_carry_a: assert property (exec && (func == AAL_INVERT_OP) |-> (fn_carry == base) && (fn_res == ~acc[src_sel])) else $error("Complement carry or value wrong");
    add_carry_a: assert property (exec && (func == AAL_ADD_OP) |-> fn_carry == (base ^ (({1'b0, acc[src_sel]} + {1'b0, acc[dst_sel]}) >= 17'h10000))) else $error("Add carry wrong");
    sub_carry_a: assert property (exec && (func == AAL_SUB_OP) |-> fn_carry == (base ^ (acc[dst_sel] >= acc[src_sel]))) else $error("Subtract carry wrong");
    rot_left_a: assert property (exec && (rot_sel == AAL_ROT_LEFT) |-> (sh_word[16] == fn_res[15]) && (sh_word[0] == fn_carry)) else $error("Left rotate wrong");
    rot_right_a: assert property (exec && (rot_sel == AAL_ROT_RIGHT) |-> (sh_word[16] == fn_res[0]) && (sh_word[15] == fn_carry)) else $error("Right rotate wrong");
    swap_bytes_a: assert property (exec && (rot_sel == AAL_ROT_SWAP) |-> (sh_word[16] == fn_carry) && (sh_word[15:8] == fn_res[7:0])) else $error("Byte swap wrong");
    skip_fixed_a: assert property (exec && (skip_code == AAL_SKIP_ALWAYS) |=> o_skip && o_done ##1 (!o_skip || $past(exec))) else $error("Always-skip not signalled");
    skip_never_a: assert property (exec && (skip_code == AAL_SKIP_NEVER) |=> !o_skip) else $error("Never-skip signalled a skip");
    skip_result_a: assert property (exec && (skip_code == 3'h5) && no_load |=> o_skip == ($past(sh_word[15:0]) != 16'h0000)) else $error("Nonzero-result skip wrong");
    inc_wrap_a: assert property (exec && (func == AAL_INC_OP) && (acc[src_sel] == 16'hFFFF) |-> (fn_res == 16'h0000) && (fn_carry == !base)) else $error("Increment wrap wrong");

endmodule // aal_core

// ### bench/aal_seq_model.sv
// Purpose: Sequencer model offering operate words and acting on skips
// Assumes: One word offered per call; result sampled one edge after take
// Notes:   Instruction lines show the inverse of the last word once its offer ends
`timescale 1ns/10ps
module aal_seq_model
(
    // Clock
    input  wire logic        i_ref_clk,
    // Answer from the datapath
    input  wire logic        i_done,
    input  wire logic        i_skip,
    // Offer to the datapath
    output logic             o_instr_valid,
    output logic [15:0]      o_instr
);
    import aal_pkg::*;

    int pc = 0;

    initial
    begin
        o_instr_valid = 1'b0;
        o_instr       = 16'h0000;
    end

    // ==================================================
    // Issue one word, return done and skip
    task automatic issue(input logic [15:0] w, output logic d, output logic s);
        @(posedge i_ref_clk);
        o_instr_valid <= 1'b1;
        o_instr       <= w;
        @(posedge i_ref_clk);
        o_instr_valid <= 1'b0;
        // Stale word would hide a decoder that ignores valid
        o_instr       <= ~w;
        @(posedge i_ref_clk);
        d = i_done;
        s = i_skip;
        pc = pc + ((s === 1'b1) ? 2 : 1);
    endtask
endmodule // aal_seq_model

// ### bench/accumulator_alu_carry_shift_skip_bench.sv
// Purpose: Self-checking bench for the accumulator ALU core
// Assumes: Operands loaded over AXI4-Lite before each instruction
// Notes:   Integer model predicts skip, accumulators and carry
`timescale 1ns/10ps
module accumulator_alu_carry_shift_skip_bench;
    import aal_pkg::*;

    // ==================================================
    // Signals
    logic        i_ref_clk = 1'b0;
    logic        i_rst_b   = 1'b0;
    logic        instr_valid;
    logic [15:0] instr;
    logic        done;
    logic        skip;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          acc [4];
    int          cy = 0;

    aal_core dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_instr_valid(instr_valid),
        .i_instr(instr), .o_done(done), .o_skip(skip), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp));

    aal_seq_model seq_u (.i_ref_clk(i_ref_clk), .i_done(done), .i_skip(skip),
        .o_instr_valid(instr_valid), .o_instr(instr));

    // ==================================================
    // Checking and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        cmp_count++;
        if (seen !== expv)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_ref_clk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        bready  <= 1'b1;
        forever
        begin
            @(posedge i_ref_clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_ref_clk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        forever
        begin
            @(posedge i_ref_clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // ==================================================
    // Reference model of one operate word
    function automatic void ref_exec(input logic [15:0] w, output int dn, output int sk);
        int s, d, base, co, res, c, oc, orr;
        dn = w[15];
        sk = 0;
        if (!w[15]) return;
        s = acc[w[14:13]];
        d = acc[w[12:11]];
        base = (w[5:4] == 0) ? cy : (w[5:4] == 1) ? 0 : (w[5:4] == 2) ? 1 : 1 - cy;
        co = 0;
        case (w[10:8])
            0: res = ~s & 32'h0000FFFF;
            1: begin res = (-s) & 32'h0000FFFF; co = (s == 0); end
            2: res = s;
            3: begin res = (s + 1) & 32'h0000FFFF; co = (s == 32'h0000FFFF); end
            4: begin res = (d + (~s & 32'h0000FFFF)) & 32'h0000FFFF; co = (d > s); end
            5: begin res = (d - s) & 32'h0000FFFF; co = (d >= s); end
            6: begin res = (d + s) & 32'h0000FFFF; co = (d + s >= 32'h00010000); end
            default: res = s & d;
        endcase
        c = base ^ co;
        oc = c;
        orr = res;
        case (w[7:6])
            1: begin oc = res >> 15; orr = ((res << 1) | c) & 32'h0000FFFF; end
            2: begin oc = res & 1; orr = (c << 15) | (res >> 1); end
            3: orr = ((res & 32'h000000FF) << 8) | (res >> 8);
            default: ;
        endcase
        case (w[2:0])
            0: sk = 0;
            1: sk = 1;
            2: sk = (oc == 0);
            3: sk = (oc != 0);
            4: sk = (orr == 0);
            5: sk = (orr != 0);
            6: sk = (oc == 0) || (orr == 0);
            default: sk = (oc != 0) && (orr != 0);
        endcase
        if (!w[3])
        begin
            acc[w[12:11]] = orr;
            cy = oc;
        end
    endfunction

    // ==================================================
    // Clock, watchdog and tests
    initial
    begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    initial
    begin
        // About five times the expected run of the scenarios below
        #500000;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] w;
        logic        dn_s, sk_s;
        int          seed, v, edn, esk, lw;
        seed = $urandom(32'h6FFF4FDA);
        lw = 0;
        repeat (3) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        for (int k = 0; k < 4; k++)
        begin
            axr(AAL_REG_ACC0 + 8'(4 * k), d, r);
            chk(d, 32'h00000000);
        end
        axr(8'h40, d, r);
        chk({d[29:0], r}, {30'h0, AAL_RESP_SLVERR});
        axw(8'h40, 32'h0000FFFF, r);
        chk(r, AAL_RESP_SLVERR);
        for (int i = 0; i < 256; i++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                v = $urandom % 4;
                v = (v == 0) ? 0 : (v == 1) ? 32'h0000FFFF : (v == 2) ? acc[0] : $urandom % 65536;
                axw(AAL_REG_ACC0 + 8'(4 * k), v, r);
                acc[k] = v;
            end
            cy = $urandom % 2;
            axw(AAL_REG_CARRY, cy, r);
            w = 16'($urandom);
            w[10:8] = i[2:0];
            w[7:6] = i[4:3];
            w[5:4] = i[6:5];
            w[15] = ($urandom % 8) != 0;
            ref_exec(w, edn, esk);
            if (edn != 0)
            begin
                lw = w;
            end
            // Upper half issues through the register port instead
            if (i[7])
            begin
                axw(AAL_REG_INSTR, {16'h0000, w}, r);
                chk(r, AAL_RESP_OKAY);
                axr(AAL_REG_INSTR, d, r);
                chk(d, lw);
            end
            else
            begin
                seq_u.issue(w, dn_s, sk_s);
                chk(dn_s, edn);
                chk(sk_s, esk);
            end
            axr(AAL_REG_ACC0 + {3'h0, w[12:11], 2'h0}, d, r);
            chk(d, acc[w[12:11]]);
            axr(AAL_REG_CARRY, d, r);
            chk(d, cy);
            // Skip pulse has long gone, so only the carry shows
            axr(AAL_REG_STATUS, d, r);
            chk(d, cy);
        end
        tally_and_finish();
    end
endmodule // accumulator_alu_carry_shift_skip_bench
